// *** hw/cirq_params.svh ***
// Build defaults, reset values and field widths of the interrupt block
`ifndef CIRQ_PARAMS_SVH
`define CIRQ_PARAMS_SVH

`define CIRQ_STAT_W 15
`define CIRQ_STAT_RST 15'h0000
`define CIRQ_EN_RST 15'h0000
`define CIRQ_RX_DEPTH_DEF 2
`define CIRQ_TX_DEPTH_DEF 2
`define CIRQ_NUM_ACF_DEF 0
`define CIRQ_NUM_ACF_MAX 4
`define CIRQ_SEL_W 2
`define CIRQ_BUS_W 32
`define CIRQ_ID_W 32
`define CIRQ_CNT_W 7
`define CIRQ_CNT_RST 7'h00
`define CIRQ_WIN_MIN 32'h0000_0100
`define CIRQ_WIN_LOW_MASK 32'h0000_00FF
`define CIRQ_MAP_BASE_DEF 32'h8000_0000
`define CIRQ_MAP_TOP_DEF 32'h8000_00FF

`endif

// *** hw/cirq_pkg.sv ***
// Types and shared decode functions of the interrupt block
`include "cirq_params.svh"

package cirq_pkg;

   typedef logic [`CIRQ_STAT_W-1:0] cirq_stat_t;
   typedef logic [`CIRQ_BUS_W-1:0] cirq_word_t;
   typedef logic [`CIRQ_ID_W-1:0] cirq_id_t;
   typedef logic [`CIRQ_CNT_W-1:0] cirq_cnt_t;
   typedef logic [`CIRQ_SEL_W-1:0] cirq_sel_t;

   // Queue depth is one of 2, 4, 8, 16, 32 or 64 messages
   function automatic logic cirq_depth_ok(input int depth);
      logic ok;
      ok = (depth == 2) || (depth == 4) || (depth == 8) ||
           (depth == 16) || (depth == 32) || (depth == 64);
      return ok;
   endfunction : cirq_depth_ok

   // Message count after one cycle of push and pop requests
   function automatic cirq_cnt_t cirq_count_next(input cirq_cnt_t cnt,
         input logic push, input logic pop, input cirq_cnt_t depth);
      logic do_push;
      logic do_pop;
      cirq_cnt_t res;
      do_push = push && (cnt < depth);
      do_pop = pop && (cnt != `CIRQ_CNT_RST);
      res = cnt;
      if (do_push && !do_pop) begin
         res = cnt + 7'h01;
      end else if (do_pop && !do_push) begin
         res = cnt - 7'h01;
      end
      return res;
   endfunction : cirq_count_next

endpackage : cirq_pkg

// *** hw/cirq_filter_pair.sv ***
// One acceptance filter pair: mask and identifier with a use flag
`timescale 1ns/100ps

module cirq_filter_pair
   import cirq_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration writes
   input wire logic wr_in,
   input wire logic use_in,
   input wire cirq_pkg::cirq_id_t mask_in,
   input wire cirq_pkg::cirq_id_t id_in,
   // Match
   input wire cirq_pkg::cirq_id_t msg_id_in,
   output logic match_out
);
   cirq_id_t mask;
   cirq_id_t ident;
   logic active;

   // Mask and identifier survive reset, as filter contents do
   always_ff @(posedge clk_in) begin
      if (wr_in) begin
         mask <= mask_in;
         ident <= id_in;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         active <= 1'b0;
      end else if (wr_in) begin
         active <= use_in;
      end
   end

   // Mask bit one compares, zero ignores: one identifier or a range
   always_comb begin
      match_out = active && (((msg_id_in ^ ident) & mask) == '0);
   end

endmodule : cirq_filter_pair

// *** hw/cirq_top.sv ***
// Interrupt event generation and build parameters of the CAN controller
`timescale 1ns/100ps
`include "cirq_params.svh"

module cirq_top
   import cirq_pkg::*;
#(
   parameter int RX_QUEUE_DEPTH_PARAM = `CIRQ_RX_DEPTH_DEF,
   parameter int TX_QUEUE_DEPTH_PARAM = `CIRQ_TX_DEPTH_DEF,
   parameter int FILTER_PAIR_COUNT_PARAM = `CIRQ_NUM_ACF_DEF,
   parameter logic [31:0] MAP_BASE_PARAM = `CIRQ_MAP_BASE_DEF,
   parameter logic [31:0] MAP_TOP_PARAM = `CIRQ_MAP_TOP_DEF,
   parameter int BUS_ADDR_W = `CIRQ_BUS_W,
   parameter int BUS_DATA_W = `CIRQ_BUS_W
)
(
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   // Interrupt events and register writes
   input wire cirq_pkg::cirq_stat_t STATUS_SET_IN,
   input wire logic ENABLE_WR_IN,
   input wire cirq_pkg::cirq_stat_t ENABLE_DATA_IN,
   input wire logic CLEAR_WR_IN,
   input wire cirq_pkg::cirq_stat_t CLEAR_DATA_IN,
   // Queue occupancy requests
   input wire logic RX_PUSH_IN,
   input wire logic RX_POP_IN,
   input wire logic TX_PUSH_IN,
   input wire logic TX_POP_IN,
   // Acceptance filter configuration and check
   input wire logic FILTER_WR_IN,
   input wire cirq_pkg::cirq_sel_t FILTER_SEL_IN,
   input wire logic FILTER_USE_IN,
   input wire cirq_pkg::cirq_id_t FILTER_MASK_IN,
   input wire cirq_pkg::cirq_id_t FILTER_ID_IN,
   input wire logic MSG_CHECK_IN,
   input wire cirq_pkg::cirq_id_t MSG_ID_IN,
   // Interrupt outputs
   output logic IRQ_EVENT_OUT,
   output cirq_pkg::cirq_stat_t INTERRUPT_STATUS_OUT,
   output cirq_pkg::cirq_stat_t INTERRUPT_ENABLE_OUT,
   // Queue state
   output cirq_pkg::cirq_cnt_t RX_COUNT_OUT,
   output logic RX_FULL_OUT,
   output logic RX_EMPTY_OUT,
   output cirq_pkg::cirq_cnt_t TX_COUNT_OUT,
   output logic TX_FULL_OUT,
   output logic TX_EMPTY_OUT,
   // Filter result and build check
   output logic MSG_ACCEPT_OUT,
   output logic MSG_DONE_OUT,
   output logic CONFIG_OK_OUT
);
   import cirq_pkg::*;

   localparam cirq_cnt_t RX_DEPTH = cirq_cnt_t'(RX_QUEUE_DEPTH_PARAM);
   localparam cirq_cnt_t TX_DEPTH = cirq_cnt_t'(TX_QUEUE_DEPTH_PARAM);
   localparam logic [31:0] MAP_RANGE = MAP_TOP_PARAM - MAP_BASE_PARAM +
                                       32'h0000_0001;

   // Build-time legality of every parameter
   localparam logic RX_OK = cirq_depth_ok(RX_QUEUE_DEPTH_PARAM);
   localparam logic TX_OK = cirq_depth_ok(TX_QUEUE_DEPTH_PARAM);
   localparam logic ACF_OK = (FILTER_PAIR_COUNT_PARAM >= 0) &&
      (FILTER_PAIR_COUNT_PARAM <= `CIRQ_NUM_ACF_MAX);
   localparam logic MAP_OK = (MAP_TOP_PARAM > MAP_BASE_PARAM) &&
      (MAP_RANGE >= `CIRQ_WIN_MIN) &&
      ((MAP_RANGE & (MAP_RANGE - 32'h0000_0001)) == 32'h0000_0000) &&
      ((MAP_BASE_PARAM & (MAP_RANGE - 32'h0000_0001)) == 32'h0000_0000) &&
      ((MAP_BASE_PARAM & `CIRQ_WIN_LOW_MASK) == 32'h0000_0000);
   localparam logic BUS_OK = (BUS_ADDR_W == `CIRQ_BUS_W) &&
      (BUS_DATA_W == `CIRQ_BUS_W);

   cirq_stat_t status;
   cirq_stat_t enable;
   cirq_stat_t next_status;
   cirq_stat_t next_enable;
   cirq_stat_t clear_hit;
   cirq_stat_t enable_fall;
   logic drop_now;
   logic next_irq;
   cirq_cnt_t rx_count;
   cirq_cnt_t tx_count;
   cirq_cnt_t next_rx_count;
   cirq_cnt_t next_tx_count;
   logic [`CIRQ_NUM_ACF_MAX-1:0] pair_match;
   logic any_match;

   // Status update: events set, ones in clear write clear, set wins
   always_comb begin
      clear_hit = CLEAR_WR_IN ? CLEAR_DATA_IN : '0;
      next_status = (status & ~clear_hit) | STATUS_SET_IN;
   end

   always_comb begin
      next_enable = ENABLE_WR_IN ? ENABLE_DATA_IN : enable;
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         status <= `CIRQ_STAT_RST;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         enable <= `CIRQ_EN_RST;
      end else begin
         enable <= next_enable;
      end
   end

   // Deassertion conditions seen in this cycle
   always_comb begin
      enable_fall = ENABLE_WR_IN ? (enable & ~ENABLE_DATA_IN) : '0;
      drop_now = |(clear_hit & status & enable) ||
                 |(enable_fall & status);
      next_irq = |(next_status & next_enable);
   end

   // Event output: a drop takes one cycle low, then the level returns
   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         IRQ_EVENT_OUT <= 1'b0;
      end else if (drop_now) begin
         IRQ_EVENT_OUT <= 1'b0;
      end else begin
         IRQ_EVENT_OUT <= next_irq;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         INTERRUPT_STATUS_OUT <= `CIRQ_STAT_RST;
         INTERRUPT_ENABLE_OUT <= `CIRQ_EN_RST;
      end else begin
         INTERRUPT_STATUS_OUT <= next_status;
         INTERRUPT_ENABLE_OUT <= next_enable;
      end
   end

   // Message occupancy of the two queues, in whole messages
   always_comb begin
      next_rx_count = cirq_count_next(rx_count, RX_PUSH_IN, RX_POP_IN,
                                      RX_DEPTH);
      next_tx_count = cirq_count_next(tx_count, TX_PUSH_IN, TX_POP_IN,
                                      TX_DEPTH);
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         rx_count <= `CIRQ_CNT_RST;
      end else begin
         rx_count <= next_rx_count;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         tx_count <= `CIRQ_CNT_RST;
      end else begin
         tx_count <= next_tx_count;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         RX_COUNT_OUT <= `CIRQ_CNT_RST;
         RX_FULL_OUT <= 1'b0;
         RX_EMPTY_OUT <= 1'b1;
      end else begin
         RX_COUNT_OUT <= next_rx_count;
         RX_FULL_OUT <= (next_rx_count == RX_DEPTH);
         RX_EMPTY_OUT <= (next_rx_count == `CIRQ_CNT_RST);
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         TX_COUNT_OUT <= `CIRQ_CNT_RST;
         TX_FULL_OUT <= 1'b0;
         TX_EMPTY_OUT <= 1'b1;
      end else begin
         TX_COUNT_OUT <= next_tx_count;
         TX_FULL_OUT <= (next_tx_count == TX_DEPTH);
         TX_EMPTY_OUT <= (next_tx_count == `CIRQ_CNT_RST);
      end
   end

   // Acceptance filter pairs, only as many as the build asks for
   genvar g;
   generate
      for (g = 0; g < `CIRQ_NUM_ACF_MAX; g = g + 1) begin : g_pair
         if (g < FILTER_PAIR_COUNT_PARAM) begin : g_used
            cirq_filter_pair u_pair (
               .clk_in(CLOCK_IN),
               .rst_in(SYS_RST_IN),
               .wr_in(FILTER_WR_IN &&
                      (FILTER_SEL_IN == cirq_sel_t'(g))),
               .use_in(FILTER_USE_IN),
               .mask_in(FILTER_MASK_IN),
               .id_in(FILTER_ID_IN),
               .msg_id_in(MSG_ID_IN),
               .match_out(pair_match[g])
            );
         end else begin : g_unused
            assign pair_match[g] = 1'b0;
         end
      end
   endgenerate

   // With no pairs built every message is accepted
   always_comb begin
      if (FILTER_PAIR_COUNT_PARAM == 0) begin
         any_match = 1'b1;
      end else begin
         any_match = |pair_match;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         MSG_ACCEPT_OUT <= 1'b0;
         MSG_DONE_OUT <= 1'b0;
      end else begin
         MSG_ACCEPT_OUT <= MSG_CHECK_IN && any_match;
         MSG_DONE_OUT <= MSG_CHECK_IN;
      end
   end

   always_ff @(posedge CLOCK_IN) begin
      if (SYS_RST_IN) begin
         CONFIG_OK_OUT <= 1'b0;
      end else begin
         CONFIG_OK_OUT <= RX_OK && TX_OK && ACF_OK && MAP_OK && BUS_OK;
      end
   end

endmodule : cirq_top

// *** testbench/cirq_host.sv ***
// Host model that writes the enable and clear registers
`timescale 1ns/100ps

module cirq_host
   import cirq_pkg::*;
(
   // Clock
   input wire logic clk_in,
   // Register writes
   output logic en_wr_out,
   output cirq_pkg::cirq_stat_t en_data_out,
   output logic clr_wr_out,
   output cirq_pkg::cirq_stat_t clr_data_out
);
   initial begin
      en_wr_out = 1'b0;
      clr_wr_out = 1'b0;
      en_data_out = '0;
      clr_data_out = '0;
   end

   // One strobe cycle from a falling edge; idle data lines show the inverse
   task automatic wr(input logic clr, input cirq_stat_t d);
      if (clr) begin
         clr_wr_out = 1'b1;
         clr_data_out = d;
      end else begin
         en_wr_out = 1'b1;
         en_data_out = d;
      end
      @(negedge clk_in);
      en_wr_out = 1'b0;
      clr_wr_out = 1'b0;
      en_data_out = ~d;
      clr_data_out = ~d;
   endtask : wr
endmodule : cirq_host

// *** testbench/cirq_chk.sv ***
// Port checker for the interrupt block
`timescale 1ns/100ps

module cirq_chk
   import cirq_pkg::*;
#(parameter int RX_QUEUE_DEPTH_PARAM = 2)
(
   // Clock and reset
   input wire logic CLOCK_IN,
   input wire logic SYS_RST_IN,
   // Inputs watched
   input wire cirq_pkg::cirq_stat_t STATUS_SET_IN,
   input wire logic ENABLE_WR_IN,
   input wire cirq_pkg::cirq_stat_t ENABLE_DATA_IN,
   input wire logic CLEAR_WR_IN,
   input wire cirq_pkg::cirq_stat_t CLEAR_DATA_IN,
   input wire logic MSG_CHECK_IN,
   // Outputs watched
   input wire logic IRQ_EVENT_OUT,
   input wire cirq_pkg::cirq_stat_t INTERRUPT_STATUS_OUT,
   input wire cirq_pkg::cirq_stat_t INTERRUPT_ENABLE_OUT,
   input wire cirq_pkg::cirq_cnt_t RX_COUNT_OUT,
   input wire logic RX_FULL_OUT,
   input wire logic MSG_DONE_OUT
);
   cirq_stat_t se;
   cirq_stat_t clr_only;
   logic drop;
   assign se = INTERRUPT_STATUS_OUT & INTERRUPT_ENABLE_OUT;
   assign clr_only = CLEAR_DATA_IN & ~STATUS_SET_IN;
   assign drop = (CLEAR_WR_IN && |(clr_only & se)) ||
                 (ENABLE_WR_IN && |(se & ~ENABLE_DATA_IN));
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (SYS_RST_IN);

   property p_set;
      1 |=> (INTERRUPT_STATUS_OUT & $past(STATUS_SET_IN)) ==
            $past(STATUS_SET_IN);
   endproperty
   a_set: assert property (p_set) else $error("status bit not set");
   property p_clr;
      CLEAR_WR_IN |=> !(|(INTERRUPT_STATUS_OUT & $past(clr_only)));
   endproperty
   a_clr: assert property (p_clr) else $error("status bit not cleared");
   property p_en;
      ENABLE_WR_IN |=> INTERRUPT_ENABLE_OUT == $past(ENABLE_DATA_IN);
   endproperty
   a_en: assert property (p_en) else $error("enable not written");
   property p_level;
      !drop && !(CLEAR_WR_IN && |STATUS_SET_IN) |=> IRQ_EVENT_OUT == |se;
   endproperty
   a_level: assert property (p_level) else $error("event level wrong");
   property p_drop;
      drop |=> !IRQ_EVENT_OUT;
   endproperty
   a_drop: assert property (p_drop) else $error("event not dropped");
   property p_rise;
      ENABLE_WR_IN && !CLEAR_WR_IN && !drop &&
      |(ENABLE_DATA_IN & ~INTERRUPT_ENABLE_OUT & INTERRUPT_STATUS_OUT)
      |=> IRQ_EVENT_OUT;
   endproperty
   a_rise: assert property (p_rise) else $error("event not raised");
   property p_init;
      $fell(SYS_RST_IN) |-> !IRQ_EVENT_OUT;
   endproperty
   a_init: assert property (p_init) else $error("event high at reset");
   property p_full;
      RX_COUNT_OUT <= RX_QUEUE_DEPTH_PARAM &&
      RX_FULL_OUT == (RX_COUNT_OUT == RX_QUEUE_DEPTH_PARAM);
   endproperty
   a_full: assert property (p_full) else $error("queue count wrong");
   property p_done;
      1 |=> MSG_DONE_OUT == $past(MSG_CHECK_IN);
   endproperty
   a_done: assert property (p_done) else $error("check result late");
   c_drop: cover property (drop);
   c_full: cover property (RX_FULL_OUT);
   c_done: cover property (MSG_DONE_OUT);
endmodule : cirq_chk

bind cirq_top cirq_chk #(.RX_QUEUE_DEPTH_PARAM(RX_QUEUE_DEPTH_PARAM))
   i_cirq_chk (
   .CLOCK_IN(CLOCK_IN),
   .SYS_RST_IN(SYS_RST_IN),
   .STATUS_SET_IN(STATUS_SET_IN),
   .ENABLE_WR_IN(ENABLE_WR_IN),
   .ENABLE_DATA_IN(ENABLE_DATA_IN),
   .CLEAR_WR_IN(CLEAR_WR_IN),
   .CLEAR_DATA_IN(CLEAR_DATA_IN),
   .MSG_CHECK_IN(MSG_CHECK_IN),
   .IRQ_EVENT_OUT(IRQ_EVENT_OUT),
   .INTERRUPT_STATUS_OUT(INTERRUPT_STATUS_OUT),
   .INTERRUPT_ENABLE_OUT(INTERRUPT_ENABLE_OUT),
   .RX_COUNT_OUT(RX_COUNT_OUT),
   .RX_FULL_OUT(RX_FULL_OUT),
   .MSG_DONE_OUT(MSG_DONE_OUT)
);

// *** testbench/cirq_top_test.sv ***
// Self-checking testbench for the interrupt block
`timescale 1ns/100ps

module cirq_top_test;
   import cirq_pkg::*;
   localparam int TXD = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rxp = 1'b0, rxq = 1'b0, txp = 1'b0, txq = 1'b0;
   logic fwr = 1'b0, fuse = 1'b1, mchk = 1'b0;
   cirq_stat_t set = '0;
   cirq_sel_t fsel = '0;
   cirq_id_t fmask = '0, fid = '0, mid = '0;
   logic ewr, cwr, irq, rxf, rxe, txf, txe, acc, done, cfg;
   cirq_stat_t ed, cd, stat, en;
   cirq_cnt_t rxc, txc;
   int miscompares = 0;
   int cmp_count = 0;

   initial begin
      forever #12.5 clk = ~clk;
   end

   cirq_host i_cirq_host (.clk_in(clk), .en_wr_out(ewr), .en_data_out(ed),
      .clr_wr_out(cwr), .clr_data_out(cd));
   cirq_top #(.TX_QUEUE_DEPTH_PARAM(TXD), .FILTER_PAIR_COUNT_PARAM(1))
   i_cirq_top (.CLOCK_IN(clk), .SYS_RST_IN(rst), .STATUS_SET_IN(set),
      .ENABLE_WR_IN(ewr), .ENABLE_DATA_IN(ed), .CLEAR_WR_IN(cwr),
      .CLEAR_DATA_IN(cd), .RX_PUSH_IN(rxp), .RX_POP_IN(rxq),
      .TX_PUSH_IN(txp), .TX_POP_IN(txq), .FILTER_WR_IN(fwr),
      .FILTER_SEL_IN(fsel), .FILTER_USE_IN(fuse), .FILTER_MASK_IN(fmask),
      .FILTER_ID_IN(fid), .MSG_CHECK_IN(mchk), .MSG_ID_IN(mid),
      .IRQ_EVENT_OUT(irq), .INTERRUPT_STATUS_OUT(stat),
      .INTERRUPT_ENABLE_OUT(en), .RX_COUNT_OUT(rxc), .RX_FULL_OUT(rxf),
      .RX_EMPTY_OUT(rxe), .TX_COUNT_OUT(txc), .TX_FULL_OUT(txf),
      .TX_EMPTY_OUT(txe), .MSG_ACCEPT_OUT(acc), .MSG_DONE_OUT(done),
      .CONFIG_OK_OUT(cfg));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic pulse_set(input cirq_stat_t d);
      set = d;
      @(negedge clk);
      set = '0;
   endtask : pulse_set

   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(irq, 0);
      chk(rxe, 1);
      chk(cfg, 1);
      $display("reset test done");
      pulse_set(15'h0008);
      chk(stat, 15'h0008);
      chk(irq, 0);
      i_cirq_host.wr(1'b0, 15'h0008);
      chk(irq, 1);
      @(negedge clk);
      chk(irq, 1);
      i_cirq_host.wr(1'b1, 15'h0000);
      chk(stat, 15'h0008);
      @(negedge clk);
      i_cirq_host.wr(1'b1, 15'h0008);
      chk(irq, 0);
      chk(stat, 0);
      pulse_set(15'h0008);
      chk(irq, 1);
      @(negedge clk);
      pulse_set(15'h0006);
      i_cirq_host.wr(1'b0, 15'h0002);
      chk(irq, 0);
      @(negedge clk);
      chk(irq, 1);
      i_cirq_host.wr(1'b0, 15'h0000);
      chk(irq, 0);
      @(negedge clk);
      chk(irq, 0);
      chk(stat, 15'h000E);
      $display("interrupt test done");
      for (int i = 1; i <= 5; i++) begin
         rxp = 1'b1;
         txp = 1'b1;
         @(negedge clk);
         chk(rxc, (i < 2) ? i : 2);
         chk(txc, (i < TXD) ? i : TXD);
      end
      chk(rxf, 1);
      chk(txf, 1);
      chk(rxe, 0);
      chk(txe, 0);
      rxp = 1'b0;
      txp = 1'b0;
      rxq = 1'b1;
      txq = 1'b1;
      repeat (5) @(negedge clk);
      rxq = 1'b0;
      txq = 1'b0;
      chk(rxe, 1);
      chk(txe, 1);
      $display("queue test done");
      fwr = 1'b1;
      fmask = 32'hFFFF_FF00;
      fid = 32'h0000_0100;
      @(negedge clk);
      fwr = 1'b0;
      mchk = 1'b1;
      mid = 32'h0000_01AB;
      @(negedge clk);
      chk(done, 1);
      chk(acc, 1);
      mid = 32'h0000_0200;
      @(negedge clk);
      mchk = 1'b0;
      chk(acc, 0);
      fsel = 2'h1;
      fmask = '0;
      fwr = 1'b1;
      @(negedge clk);
      fwr = 1'b0;
      mchk = 1'b1;
      @(negedge clk);
      mchk = 1'b0;
      chk(done, 1);
      chk(acc, 0);
      fsel = 2'h0;
      fuse = 1'b0;
      fmask = 32'hFFFF_FF00;
      mid = 32'h0000_01AB;
      fwr = 1'b1;
      @(negedge clk);
      fwr = 1'b0;
      mchk = 1'b1;
      @(negedge clk);
      mchk = 1'b0;
      chk(done, 1);
      chk(acc, 0);
      $display("filter test done");
      i_cirq_host.wr(1'b0, 15'h0002);
      chk(irq, 1);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      chk(irq, 0);
      chk(stat, 0);
      $display("second reset test done");
      end_sim();
   end
endmodule : cirq_top_test
